// [src/twi_map.vh]
// Register map, field positions, reset values and status codes for the two-wire block
// Assumes APB byte addressing with one 32-bit word per register
`ifndef TWI_MAP_VH
`define TWI_MAP_VH
`define TWI_OFF_CTRL 12'h000
`define TWI_OFF_STAT 12'h004
`define TWI_OFF_DATA 12'h008
`define TWI_OFF_ADDR 12'h00c
`define TWI_OFF_BAUD 12'h010
`define TWI_OFF_SLEEP 12'h014
`define TWI_B_IRQ 7
`define TWI_B_ACK 6
`define TWI_B_STA 5
`define TWI_B_STO 4
`define TWI_B_WCOL 3
`define TWI_B_EN 2
`define TWI_B_IE 0
`define TWI_RST_CTRL 8'h00
`define TWI_RST_ADDR 8'hfe
`define TWI_RST_BAUD 8'h20
`define TWI_RST_STAT 5'h1f
`define TWI_ST_START 5'h01
`define TWI_ST_RSTART 5'h02
`define TWI_ST_MT_AACK 5'h03
`define TWI_ST_MT_ANACK 5'h04
`define TWI_ST_ARB 5'h07
`define TWI_ST_MR_AACK 5'h08
`define TWI_ST_MR_ANACK 5'h09
`define TWI_ST_MR_DACK 5'h0a
`define TWI_ST_MR_DNACK 5'h0b
`define TWI_ST_SR_AACK 5'h0c
`define TWI_ST_SR_ARB 5'h0d
`define TWI_ST_SR_GACK 5'h0e
`define TWI_ST_SR_GARB 5'h0f
`define TWI_ST_SR_DACK 5'h10
`define TWI_ST_SR_DNACK 5'h11
`define TWI_ST_SR_GDACK 5'h12
`define TWI_ST_SR_GDNACK 5'h13
`define TWI_ST_SR_STOP 5'h14
`define TWI_ST_ST_AACK 5'h15
`define TWI_ST_IDLE 5'h1f
`endif

// [src/twi_core.v]
// Two-wire serial interface: master receiver, master transmitter addressing, slave receiver
// Assumes APB master on pclk; scl/sda are open-drain pins resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "twi_map.vh"
module twi_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  output wire wake
);
  localparam S_IDLE = 7'b0000001;
  localparam S_START = 7'b0000010;
  localparam S_BIT = 7'b0000100;
  localparam S_ACK = 7'b0001000;
  localparam S_WAIT = 7'b0010000;
  localparam S_STOP = 7'b0100000;
  localparam S_SLV = 7'b1000000;
  reg [7:0] ctrl, own, baud, data, shreg;
  reg [4:0] stat;
  reg deep_sleep;
  reg [1:0] scl_s, sda_s;
  reg scl_d, sda_d, busy, stretch, wake_r;
  reg [6:0] st;
  reg [2:0] step;
  reg [3:0] bitn;
  reg [7:0] cnt;
  reg master, rx, is_addr, gc, lost, drv_sda, drv_scl, pend_rs;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire irq = ctrl[`TWI_B_IRQ];
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_seen = scl_s[1] & sda_d & ~sda_s[1];
  wire stop_seen = scl_s[1] & ~sda_d & sda_s[1];
  wire tick = (cnt == 8'h00);
  wire clr_irq = wr & (paddr == `TWI_OFF_CTRL) & pwdata[`TWI_B_IRQ];
  reg set_irq;
  reg [4:0] next_stat;
  reg clr_sto;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Open-drain: only low is driven
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = drv_sda;
  assign scl_oe = drv_scl | (stretch & irq);
  assign wake = wake_r;
  // Read word captured in the setup phase, stands through the access phase
  reg [31:0] rd_word;
  always @* begin
    case (paddr)
      `TWI_OFF_CTRL: rd_word = {24'h0, ctrl};
      `TWI_OFF_STAT: rd_word = {24'h0, stat, 3'b000};
      `TWI_OFF_DATA: rd_word = {24'h0, data};
      `TWI_OFF_ADDR: rd_word = {24'h0, own};
      `TWI_OFF_BAUD: rd_word = {24'h0, baud};
      `TWI_OFF_SLEEP: rd_word = {31'h0, deep_sleep};
      default: rd_word = 32'h0;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_word;
  end
  // Pin synchronisers and bus-free tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      busy <= 1'b0;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
      if (start_seen)
        busy <= 1'b1;
      else if (stop_seen)
        busy <= 1'b0;
    end
  end
  // Software registers; hardware flag set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `TWI_RST_CTRL;
      own <= `TWI_RST_ADDR;
      baud <= `TWI_RST_BAUD;
      deep_sleep <= 1'b0;
      stat <= `TWI_RST_STAT;
    end else begin
      if (wr && paddr == `TWI_OFF_CTRL) begin
        ctrl[`TWI_B_ACK] <= pwdata[`TWI_B_ACK];
        ctrl[`TWI_B_STA] <= pwdata[`TWI_B_STA];
        ctrl[`TWI_B_STO] <= pwdata[`TWI_B_STO];
        ctrl[`TWI_B_EN] <= pwdata[`TWI_B_EN];
        ctrl[`TWI_B_IE] <= pwdata[`TWI_B_IE];
        ctrl[1] <= 1'b0;
      end
      if (wr && paddr == `TWI_OFF_ADDR)
        own <= pwdata[7:0];
      if (wr && paddr == `TWI_OFF_BAUD)
        baud <= pwdata[7:0];
      if (wr && paddr == `TWI_OFF_SLEEP)
        deep_sleep <= pwdata[0];
      if (wr && paddr == `TWI_OFF_DATA)
        ctrl[`TWI_B_WCOL] <= ~irq;
      else if (clr_irq)
        ctrl[`TWI_B_WCOL] <= 1'b0;
      if (set_irq) begin
        ctrl[`TWI_B_IRQ] <= 1'b1;
        stat <= next_stat;
      end else if (clr_irq) begin
        ctrl[`TWI_B_IRQ] <= 1'b0;
        stat <= `TWI_ST_IDLE;
      end
      if (clr_sto)
        ctrl[`TWI_B_STO] <= 1'b0;
    end
  end
  wire [7:0] own_match = {own[7:1], 1'b0};
  // Bus engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      step <= 3'h0;
      bitn <= 4'h0;
      cnt <= 8'h00;
      shreg <= 8'h00;
      data <= 8'h00;
      master <= 1'b0;
      rx <= 1'b0;
      is_addr <= 1'b0;
      gc <= 1'b0;
      lost <= 1'b0;
      drv_sda <= 1'b0;
      drv_scl <= 1'b0;
      pend_rs <= 1'b0;
      stretch <= 1'b0;
      wake_r <= 1'b0;
      set_irq <= 1'b0;
      next_stat <= `TWI_ST_IDLE;
      clr_sto <= 1'b0;
    end else begin
      set_irq <= 1'b0;
      clr_sto <= 1'b0;
      cnt <= tick ? baud : cnt - 8'h01;
      if (wr && paddr == `TWI_OFF_DATA && irq)
        data <= pwdata[7:0];
      if (clr_irq)
        wake_r <= 1'b0;
      if (!ctrl[`TWI_B_EN]) begin
        st <= S_IDLE;
        drv_sda <= 1'b0;
        drv_scl <= 1'b0;
        stretch <= 1'b0;
        master <= 1'b0;
      end else begin
        case (st)
          S_IDLE: begin
            stretch <= 1'b0;
            if (ctrl[`TWI_B_STA] && !busy && !irq && tick) begin
              st <= S_START;
              step <= 3'h0;
            end else if (start_seen) begin
              st <= S_SLV;
              bitn <= 4'h0;
              is_addr <= 1'b1;
              master <= 1'b0;
            end
          end
          S_START: if (tick) begin
            step <= step + 3'h1;
            case (step)
              3'h0: drv_scl <= 1'b0;
              3'h1: drv_sda <= 1'b1;
              3'h2: begin
                drv_scl <= 1'b1;
                master <= 1'b1;
                lost <= 1'b0;
                set_irq <= 1'b1;
                next_stat <= pend_rs ? `TWI_ST_RSTART : `TWI_ST_START;
                pend_rs <= 1'b1;
                is_addr <= 1'b1;
                st <= S_WAIT;
              end
              default: step <= 3'h0;
            endcase
          end
          S_WAIT: begin
            stretch <= 1'b1;
            if (clr_irq) begin
              stretch <= 1'b0;
              bitn <= 4'h0;
              step <= 3'h0;
              if (pwdata[`TWI_B_STO]) begin
                st <= S_STOP;
              end else if (pwdata[`TWI_B_STA] && master) begin
                st <= S_START;
                drv_sda <= 1'b0;
              end else if (master) begin
                if (is_addr)
                  rx <= data[0];
                shreg <= is_addr ? data : 8'hff;
                st <= S_BIT;
              end else begin
                // Slave side lets the clock go once software has acted
                drv_scl <= 1'b0;
                st <= S_SLV;
              end
            end
          end
          S_BIT: if (tick) begin
            step <= step + 3'h1;
            case (step)
              3'h0: drv_sda <= (is_addr | ~rx) ? ~shreg[7] : 1'b0;
              3'h1: drv_scl <= 1'b0;
              3'h2: begin
                if (drv_sda == 1'b0 && !sda_s[1] && (is_addr | ~rx) && shreg[7]) begin
                  lost <= 1'b1;
                  drv_sda <= 1'b0;
                  master <= 1'b0;
                  pend_rs <= 1'b0;
                  set_irq <= 1'b1;
                  next_stat <= `TWI_ST_ARB;
                  st <= S_SLV;
                end
                shreg <= {shreg[6:0], sda_s[1]};
              end
              3'h3: begin
                drv_scl <= 1'b1;
                step <= 3'h0;
                bitn <= bitn + 4'h1;
                if (bitn == 4'h7)
                  st <= S_ACK;
              end
              default: step <= 3'h0;
            endcase
          end
          S_ACK: if (tick) begin
            step <= step + 3'h1;
            case (step)
              // Master receiver acks per ack_enable; last byte nack is software's job
              3'h0: drv_sda <= (!is_addr && rx) ? ctrl[`TWI_B_ACK] : 1'b0;
              3'h1: drv_scl <= 1'b0;
              // Status latched while the clock is high
              3'h2: begin
                if (is_addr)
                  next_stat <= sda_s[1] ? (rx ? `TWI_ST_MR_ANACK : `TWI_ST_MT_ANACK)
                                        : (rx ? `TWI_ST_MR_AACK : `TWI_ST_MT_AACK);
                else begin
                  data <= shreg;
                  next_stat <= sda_s[1] ? `TWI_ST_MR_DNACK : `TWI_ST_MR_DACK;
                end
              end
              3'h3: begin
                // Flag rises with the clock held low, never while it runs
                set_irq <= 1'b1;
                drv_scl <= 1'b1;
                drv_sda <= 1'b0;
                is_addr <= 1'b0;
                st <= S_WAIT;
              end
              default: step <= 3'h0;
            endcase
          end
          S_STOP: if (tick) begin
            step <= step + 3'h1;
            case (step)
              3'h0: drv_sda <= 1'b1;
              3'h1: drv_scl <= 1'b0;
              3'h2: begin
                drv_sda <= 1'b0;
                master <= 1'b0;
                pend_rs <= 1'b0;
                clr_sto <= 1'b1;
                st <= S_IDLE; // start follows from start_request if set
              end
              default: step <= 3'h0;
            endcase
          end
          S_SLV: begin
            // Slave side sampled on pins; deep sleep still matches address
            if (stop_seen) begin
              st <= S_IDLE;
              drv_sda <= 1'b0;
            end else if (start_seen) begin
              bitn <= 4'h0;
              is_addr <= 1'b1;
            end else if (scl_rise && bitn < 4'h8) begin
              shreg <= {shreg[6:0], sda_s[1]};
              bitn <= bitn + 4'h1;
            end else if (scl_fall && bitn == 4'h8) begin
              bitn <= 4'h9;
              if (is_addr) begin
                gc <= (shreg[7:1] == 7'h00) & own[0];
                if (ctrl[`TWI_B_ACK] && (shreg[7:1] == own_match[7:1] ||
                    (shreg[7:1] == 7'h00 && own[0]) )) begin
                  drv_sda <= ~shreg[0] | 1'b1;
                  // Address byte is not copied to the data register
                  rx <= ~shreg[0];
                end else
                  st <= S_IDLE;
              end else begin
                data <= shreg;
                drv_sda <= ctrl[`TWI_B_ACK];
              end
            end else if (scl_fall && bitn == 4'h9) begin
              drv_sda <= 1'b0;
              bitn <= 4'h0;
              set_irq <= 1'b1;
              drv_scl <= 1'b1;
              st <= S_WAIT;
              if (is_addr) begin
                // Wake raised together with the held clock
                wake_r <= deep_sleep;
                if (!shreg[0])
                  next_stat <= gc ? (lost ? `TWI_ST_SR_GARB : `TWI_ST_SR_GACK)
                                  : (lost ? `TWI_ST_SR_ARB : `TWI_ST_SR_AACK);
                else
                  next_stat <= `TWI_ST_ST_AACK;
              end else
                next_stat <= gc ? (drv_sda ? `TWI_ST_SR_GDACK : `TWI_ST_SR_GDNACK)
                                : (drv_sda ? `TWI_ST_SR_DACK : `TWI_ST_SR_DNACK);
              is_addr <= 1'b0;
              lost <= 1'b0;
            end else if (clr_irq && drv_scl) begin
              drv_scl <= 1'b0;
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end
endmodule // twi_core
`default_nettype wire

// [sim/twi_core_monitor.sv]
// Checker for the port behaviour of the two-wire core
// Assumes it is bound into twi_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module twi_core_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_acc = psel && penable && !pwrite;
  a_zero_wait: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_no_error: assert property (psel && penable |-> !pslverr)
    else $error("pslverr raised");
  a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  a_byte_wide: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_stat_mask: assert property (rd_acc && paddr == 12'h004 |-> prdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_unmapped_zero: assert property (rd_acc && paddr >= 12'h018 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_flag_stretch: assert property (rd_acc && paddr == 12'h000 && prdata[7] |-> scl_oe)
    else $error("clock free while flag set");
  a_wake_hold: assert property (wake |-> scl_oe)
    else $error("clock free during wake");
endmodule // twi_core_monitor
bind twi_core twi_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wake(wake));
`default_nettype wire

// [sim/twi_slave_model.sv]
// Behavioural slave on the two-wire bus: acks its address, sends counting bytes
// Assumes resolved scl and sda lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module twi_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a,
  parameter logic [7:0] DATA0 = 8'ha5
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  int n = 0;
  logic act = 1'b0;
  logic first = 1'b0;
  logic rd = 1'b0;
  initial sda_oe = 1'b0;
  // Start or repeated start arms the address phase
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    first = 1'b1;
    rd = 1'b0;
    n = 0;
    sda_oe = 1'b0;
    tx = DATA0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd && sda) act = 1'b0;
    n = n + 1;
  end
  always @(negedge scl) if (act) begin
    if (n == 8 && first) begin
      if (sh[7:1] == ADDR) begin
        sda_oe = 1'b1;
        rd = sh[0];
      end else act = 1'b0;
    end else if (n == 8) sda_oe = !rd;
    else if (n == 9) begin
      if (!first) tx = tx + 8'h01;
      n = 0;
      first = 1'b0;
      sda_oe = rd && !tx[7];
    end else if (rd) sda_oe = !tx[7 - n];
  end
endmodule // twi_slave_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench: master receive traffic over APB against a slave model, then slave receive with the bench as bus master
// Assumes the register map of twi_map.vh and pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
`include "twi_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] q;
  logic m_scl_low;
  logic m_sda_low;
  logic ack_seen;
  wire [31:0] prdata;
  wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake, slv_oe;
  wire scl_line = !(scl_oe || m_scl_low);
  wire sda_line = !(sda_oe || slv_oe || m_sda_low);
  int mismatches = 0;
  int checked = 0;
  twi_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wake(wake));
  twi_slave_model #(.ADDR(7'h5a), .DATA0(8'ha5)) slave (.scl(scl_line), .sda(sda_line),
    .sda_oe(slv_oe));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task wait_bit(input int b, input logic v);
    int i;
    apb(1'b0, `TWI_OFF_CTRL, 32'h0);
    for (i = 0; i < 400 && q[b] !== v; i++) apb(1'b0, `TWI_OFF_CTRL, 32'h0);
    `CHK(q[b], v)
  endtask
  // Bench as bus master: one bit, waiting out clock stretching
  task mbit(input logic b, output logic s);
    m_sda_low <= !b;
    repeat (8) @(posedge pclk);
    m_scl_low <= 1'b0;
    @(posedge pclk);
    while (scl_line !== 1'b1) @(posedge pclk);
    repeat (8) @(posedge pclk);
    s = sda_line;
    m_scl_low <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task mbyte(input logic [7:0] v, output logic a);
    int k;
    logic s;
    for (k = 7; k >= 0; k--) mbit(v[k], s);
    mbit(1'b1, a);
  endtask
  task mstart;
    m_sda_low <= 1'b1;
    repeat (8) @(posedge pclk);
    m_scl_low <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task mstop;
    m_sda_low <= 1'b1;
    repeat (8) @(posedge pclk);
    m_scl_low <= 1'b0;
    repeat (8) @(posedge pclk);
    m_sda_low <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task report_and_stop;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    m_scl_low = 1'b0;
    m_sda_low = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`TWI_OFF_CTRL, 32'h00);
    rdchk(`TWI_OFF_ADDR, 32'hfe);
    rdchk(`TWI_OFF_STAT, 32'hf8);
    rdchk(12'h040, 32'h0);
    apb(1'b1, `TWI_OFF_ADDR, 32'h5b);
    rdchk(`TWI_OFF_ADDR, 32'h5b);
    $display("register test done");
    // Bus bit time 16 pclk, 160 ns
    apb(1'b1, `TWI_OFF_BAUD, 32'h3);
    apb(1'b1, `TWI_OFF_CTRL, 32'ha4);
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h08);
    apb(1'b1, `TWI_OFF_CTRL, 32'h04);
    rdchk(`TWI_OFF_CTRL, 32'h84);
    repeat (40) @(posedge pclk);
    `CHK(scl_line, 1'b0)
    apb(1'b1, `TWI_OFF_DATA, {24'h0, 7'h5a, 1'b1});
    apb(1'b1, `TWI_OFF_CTRL, 32'hc4);
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h40);
    apb(1'b1, `TWI_OFF_CTRL, 32'hc4);
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h50);
    rdchk(`TWI_OFF_DATA, 32'ha5);
    apb(1'b1, `TWI_OFF_CTRL, 32'h84);
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h58);
    rdchk(`TWI_OFF_DATA, 32'ha6);
    $display("master read test done");
    apb(1'b1, `TWI_OFF_CTRL, 32'ha4);
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h10);
    apb(1'b1, `TWI_OFF_DATA, {24'h0, 7'h11, 1'b1});
    apb(1'b1, `TWI_OFF_CTRL, 32'h84);
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h48);
    apb(1'b1, `TWI_OFF_CTRL, 32'h94);
    wait_bit(4, 1'b0);
    repeat (40) @(posedge pclk);
    `CHK(sda_line, 1'b1)
    `CHK(scl_line, 1'b1)
    rdchk(`TWI_OFF_STAT, 32'hf8);
    apb(1'b1, `TWI_OFF_DATA, 32'h33);
    apb(1'b0, `TWI_OFF_CTRL, 32'h0);
    `CHK(q[3], 1'b1)
    $display("repeated start and stop test done");
    // Slave receiver: own address 2d with general call, bench is the master
    apb(1'b1, `TWI_OFF_SLEEP, 32'h1);
    apb(1'b1, `TWI_OFF_CTRL, 32'h44);
    mstart;
    mbyte(8'h5a, ack_seen);
    `CHK(ack_seen, 1'b0)
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h60);
    `CHK(wake, 1'b1)
    `CHK(scl_line, 1'b0)
    apb(1'b1, `TWI_OFF_SLEEP, 32'h0);
    apb(1'b1, `TWI_OFF_CTRL, 32'hc4);
    `CHK(wake, 1'b0)
    mbyte(8'h3c, ack_seen);
    `CHK(ack_seen, 1'b0)
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h80);
    rdchk(`TWI_OFF_DATA, 32'h3c);
    apb(1'b1, `TWI_OFF_CTRL, 32'h84);
    mbyte(8'hc3, ack_seen);
    `CHK(ack_seen, 1'b1)
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h88);
    apb(1'b1, `TWI_OFF_CTRL, 32'h84);
    mstop;
    mstart;
    mbyte(8'h5a, ack_seen);
    `CHK(ack_seen, 1'b1)
    mstop;
    rdchk(`TWI_OFF_CTRL, 32'h04);
    apb(1'b1, `TWI_OFF_CTRL, 32'h44);
    mstart;
    mbyte(8'h00, ack_seen);
    `CHK(ack_seen, 1'b0)
    wait_bit(7, 1'b1);
    rdchk(`TWI_OFF_STAT, 32'h70);
    apb(1'b1, `TWI_OFF_CTRL, 32'hc4);
    mstop;
    $display("slave receive test done");
    report_and_stop;
  end
  initial begin
    #300000;
    mismatches++;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
